// ### logic/aux_io_pkg.sv
// Purpose: shared types and constants for the auxiliary i/o event controller
// Assumes: 40 MHz clock
// Notes:   source codes follow the order of the event list
`default_nettype none
package aux_io_pkg;
  localparam int CLOCK_HZ       = 40000000;
  localparam int MS_PER_S       = 1000;
  localparam int CYCLES_PER_MS  = CLOCK_HZ / MS_PER_S;
  localparam int DEBOUNCE_MS_MAX = 10000000;
  localparam int DEBOUNCE_MS_W  = 24;
  localparam int STROBE_WIDTH_CYCLES = 40;
  localparam int NUM_OUTPUTS    = 4;
  localparam int NUM_INPUTS     = 3;
  localparam int RELAY_OUT_A    = 2;
  localparam int RELAY_OUT_B    = 3;
  // phase, range and speed are fixed point words handed to the phase loop
  localparam int PHASE_W        = 16;
  localparam int RANGE_W        = 16;
  localparam int SPEED_W        = 10;
  localparam logic [RANGE_W-1:0] RANGE_MIN = 16'h000A; // 0.10 Hz in 0.01 Hz
  localparam logic [RANGE_W-1:0] RANGE_MAX = 16'hC350; // 500 Hz in 0.01 Hz
  localparam logic [SPEED_W-1:0] SPEED_MIN = 10'h064;  // 1.00 in 0.01
  localparam logic [SPEED_W-1:0] SPEED_MAX = 10'h3E8;  // 10.00 in 0.01

  typedef enum logic [3:0] {
    SRC_FAULT, SRC_FORM, SRC_HIGH, SRC_LOW, SRC_RELAY,
    SRC_PROGRAM, SRC_REMOTE, SRC_TRANSIENT, SRC_TRANSFORMER
  } source_type;

  typedef enum logic [1:0] {
    CONTACT_IGNORED, CONTACT_REQUIRED, CONTACT_OR_PANEL
  } contact_mode_type;

  typedef struct packed {
    logic fault;
    logic singleForm;
    logic relayOn;
    logic programRun;
    logic remote;
    logic transientActive;
    logic transformer_path_flag;
  } status_type;

  typedef struct packed {
    logic onTransient;
    logic onRelay;
    logic onSource;
  } strobe_cfg_type;

  typedef struct packed {
    logic                 enable;
    logic                 lineSource;
    logic [PHASE_W-1:0]   phaseOffset;
    logic [RANGE_W-1:0]   lockRange;
    logic [SPEED_W-1:0]   speed;
  } sync_cfg_type;
endpackage : aux_io_pkg
`default_nettype wire

// ### logic/input_debounce.sv
// Purpose: debounce one digital input and report its edges
// Assumes: input synchronous to clock
// Notes:   a level must hold for the whole filter time before it is accepted
`default_nettype none
module input_debounce #(
  parameter int MS_W       = aux_io_pkg::DEBOUNCE_MS_W,
  parameter int CYC_PER_MS = aux_io_pkg::CYCLES_PER_MS
) (
  input  wire logic            clock,
  input  wire logic            nrst,
  input  wire logic            pinLevel,
  input  wire logic [MS_W-1:0] filterMs,
  output logic                 level,
  output logic                 rise,
  output logic                 fall
);
  logic [15:0]     cycleCount;
  logic [MS_W-1:0] msCount;
  logic            differs;
  logic            msTick;
  logic            accept;

  assign differs = pinLevel != level;
  assign msTick  = cycleCount == 16'(CYC_PER_MS - 1);
  // zero filter accepts the change at once
  assign accept  = differs && (filterMs == '0 ||
                   (msTick && msCount == filterMs - 1'b1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cycleCount <= 16'h0000;
      msCount    <= '0;
      level      <= 1'b0;
      rise       <= 1'b0;
      fall       <= 1'b0;
    end else begin
      rise <= accept && pinLevel;
      fall <= accept && !pinLevel;
      if (!differs || accept) begin
        cycleCount <= 16'h0000;
        msCount    <= '0;
      end else if (msTick) begin
        cycleCount <= 16'h0000;
        msCount    <= msCount + 1'b1;
      end else begin
        cycleCount <= cycleCount + 16'h0001;
      end
      if (accept) level <= pinLevel;
    end
  end

  a_edge_needs_change: assert property (@(posedge clock) disable iff (!nrst)
    rise |-> level && !$past(level))
    else $error("rise without a level change");
endmodule : input_debounce
`default_nettype wire

// ### logic/aux_io_event_controller.sv
// Purpose: auxiliary i/o event controller: outputs, inputs, strobe, relay
// Assumes: all inputs synchronous to clock; status comes from the core
// Notes:   the phase loop itself lives elsewhere; this block gates its setup
`default_nettype none
module aux_io_event_controller #(
  parameter int NOUT      = aux_io_pkg::NUM_OUTPUTS,
  parameter int NIN       = aux_io_pkg::NUM_INPUTS,
  parameter int MS_W      = aux_io_pkg::DEBOUNCE_MS_W,
  parameter int STROBE_CY = aux_io_pkg::STROBE_WIDTH_CYCLES
) (
  input  wire logic                              clock,
  input  wire logic                              nrst,
  input  wire aux_io_pkg::status_type            status,
  input  wire aux_io_pkg::source_type            outSource [NOUT],
  input  wire logic [NOUT-1:0]                   polarity_flip,
  input  wire logic [NIN-1:0]                    inPin,
  input  wire logic [MS_W-1:0]                   filterMs [NIN],
  input  wire aux_io_pkg::strobe_cfg_type        strobeCfg,
  input  wire logic                              paramChanged,
  input  wire aux_io_pkg::contact_mode_type      contactMode,
  input  wire logic                              contactClosed,
  input  wire logic                              panelRelayOn,
  input  wire logic                              triggerEnable,
  input  wire logic                              triggerImmediate,
  input  wire logic                              self_launch,
  input  wire logic                              triggerPin,
  input  wire logic                              runArmed,
  input  wire logic                              phaseReached,
  input  wire aux_io_pkg::sync_cfg_type          syncCfg,
  output logic                                   ttl_out_a,
  output logic                                   ttl_out_b,
  output logic                                   relayFetOn_a,
  output logic                                   relayFetOn_b,
  output logic [NIN-1:0]                         inLevel,
  output logic [NIN-1:0]                         inRise,
  output logic [NIN-1:0]                         inFall,
  output logic                                   strobe,
  output logic                                   relayClose,
  output logic                                   transientStart,
  output logic                                   syncLock,
  output logic                                   syncUseLine,
  output logic [aux_io_pkg::PHASE_W-1:0]         syncPhase,
  output logic [aux_io_pkg::RANGE_W-1:0]         syncRange,
  output logic [aux_io_pkg::SPEED_W-1:0]         syncSpeed
);
  // selects the raw event for one output
  function automatic logic pick(input aux_io_pkg::source_type s,
                                input aux_io_pkg::status_type st);
    unique case (s)
      aux_io_pkg::SRC_FAULT:       pick = st.fault;
      aux_io_pkg::SRC_FORM:        pick = st.singleForm;
      aux_io_pkg::SRC_HIGH:        pick = 1'b1;
      aux_io_pkg::SRC_LOW:         pick = 1'b0;
      aux_io_pkg::SRC_RELAY:       pick = st.relayOn;
      aux_io_pkg::SRC_PROGRAM:     pick = st.programRun;
      aux_io_pkg::SRC_REMOTE:      pick = st.remote;
      aux_io_pkg::SRC_TRANSIENT:   pick = st.transientActive;
      aux_io_pkg::SRC_TRANSFORMER: pick = st.transformer_path_flag;
      default:                     pick = 1'b0;
    endcase
  endfunction : pick

  logic [NOUT-1:0] next_out;
  logic [NOUT-1:0] outValue;

  genvar g;
  generate
    for (g = 0; g < NOUT; g++) begin : g_out
      assign next_out[g] = pick(outSource[g], status) ^ polarity_flip[g];
    end
  endgenerate

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) outValue <= '0;
    else       outValue <= next_out;
  end

  // relay outputs drive the fet gate: 1 means the pin is pulled low
  assign ttl_out_a    = outValue[0];
  assign ttl_out_b    = outValue[1];
  assign relayFetOn_a = outValue[aux_io_pkg::RELAY_OUT_A];
  assign relayFetOn_b = outValue[aux_io_pkg::RELAY_OUT_B];

  generate
    for (g = 0; g < NIN; g++) begin : g_in
      input_debounce #(
        .MS_W       (MS_W),
        .CYC_PER_MS (aux_io_pkg::CYCLES_PER_MS)
      ) u_debounce (
        .clock    (clock),
        .nrst     (nrst),
        .pinLevel (inPin[g]),
        .filterMs (filterMs[g]),
        .level    (inLevel[g]),
        .rise     (inRise[g]),
        .fall     (inFall[g])
      );
    end
  endgenerate

  // relay gating by the remote contact
  logic next_relay;
  always_comb begin
    unique case (contactMode)
      aux_io_pkg::CONTACT_REQUIRED:
        next_relay = panelRelayOn && contactClosed;
      aux_io_pkg::CONTACT_OR_PANEL:
        next_relay = panelRelayOn || contactClosed;
      default:
        next_relay = panelRelayOn;
    endcase
  end

  // trigger: waits on phase unless immediate, needs run unless self launch
  logic trigPrev;
  logic trigPending;
  logic trigEdge;
  logic trigFire;
  assign trigEdge = triggerEnable && triggerPin && !trigPrev
                    && (runArmed || self_launch);
  assign trigFire = (trigEdge || trigPending)
                    && (triggerImmediate || phaseReached);

  logic relayPrev;
  logic transPrev;
  logic strobeEvent;
  logic [7:0] strobeCount;
  assign strobeEvent =
      (strobeCfg.onTransient && status.transientActive && !transPrev)
   || (strobeCfg.onRelay && relayClose && !relayPrev)
   || (strobeCfg.onSource && paramChanged);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      relayClose     <= 1'b0;
      relayPrev      <= 1'b0;
      transPrev      <= 1'b0;
      trigPrev       <= 1'b0;
      trigPending    <= 1'b0;
      transientStart <= 1'b0;
      strobe         <= 1'b0;
      strobeCount    <= 8'h00;
    end else begin
      relayClose     <= next_relay;
      relayPrev      <= relayClose;
      transPrev      <= status.transientActive;
      trigPrev       <= triggerPin;
      transientStart <= trigFire;
      trigPending    <= (trigEdge || trigPending) && !trigFire
                        && triggerEnable;
      // strobe is stretched so slow equipment sees it
      if (strobeEvent) begin
        strobe      <= 1'b1;
        strobeCount <= 8'(STROBE_CY - 1);
      end else if (strobeCount != 8'h00) begin
        strobeCount <= strobeCount - 8'h01;
      end else begin
        strobe <= 1'b0;
      end
    end
  end

  // sync setup: range and speed clamped to their legal spans
  logic [aux_io_pkg::RANGE_W-1:0] rangeClamp;
  logic [aux_io_pkg::SPEED_W-1:0] speedClamp;
  assign rangeClamp =
      (syncCfg.lockRange < aux_io_pkg::RANGE_MIN) ? aux_io_pkg::RANGE_MIN :
      (syncCfg.lockRange > aux_io_pkg::RANGE_MAX) ? aux_io_pkg::RANGE_MAX :
      syncCfg.lockRange;
  assign speedClamp =
      (syncCfg.speed < aux_io_pkg::SPEED_MIN) ? aux_io_pkg::SPEED_MIN :
      (syncCfg.speed > aux_io_pkg::SPEED_MAX) ? aux_io_pkg::SPEED_MAX :
      syncCfg.speed;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      syncLock    <= 1'b0;
      syncUseLine <= 1'b0;
      syncPhase   <= '0;
      syncRange   <= aux_io_pkg::RANGE_MIN;
      syncSpeed   <= aux_io_pkg::SPEED_MIN;
    end else begin
      syncLock    <= syncCfg.enable;
      syncUseLine <= syncCfg.lineSource;
      syncPhase   <= syncCfg.phaseOffset;
      syncRange   <= rangeClamp;
      syncSpeed   <= speedClamp;
    end
  end

  a_output_source: assert property (@(posedge clock) disable iff (!nrst)
    ##1 outValue == $past(next_out))
    else $error("output does not follow its source");
  a_fault_output: assert property (@(posedge clock) disable iff (!nrst)
    outSource[0] == aux_io_pkg::SRC_FAULT && !polarity_flip[0]
    |=> ttl_out_a == $past(status.fault))
    else $error("fault output wrong");
  a_flip_inverts: assert property (@(posedge clock) disable iff (!nrst)
    outSource[1] == aux_io_pkg::SRC_HIGH && polarity_flip[1]
    |=> !ttl_out_b)
    else $error("flipped high output not low");
  a_relay_fet_on: assert property (@(posedge clock) disable iff (!nrst)
    outSource[2] == aux_io_pkg::SRC_HIGH && !polarity_flip[2]
    |=> relayFetOn_a)
    else $error("relay fet not on");
  a_contact_required: assert property (@(posedge clock) disable iff (!nrst)
    contactMode == aux_io_pkg::CONTACT_REQUIRED && !contactClosed
    |=> !relayClose)
    else $error("relay closed without contact");
  a_contact_ignored: assert property (@(posedge clock) disable iff (!nrst)
    contactMode == aux_io_pkg::CONTACT_IGNORED
    |=> relayClose == $past(panelRelayOn))
    else $error("contact affected relay");
  a_strobe_source: assert property (@(posedge clock) disable iff (!nrst)
    strobeCfg.onSource && paramChanged |=> strobe [*2])
    else $error("no strobe on parameter change");
  a_immediate_trig: assert property (@(posedge clock) disable iff (!nrst)
    triggerEnable && triggerImmediate && runArmed && triggerPin
    && !trigPrev |=> transientStart)
    else $error("immediate trigger did not start");
  a_sync_range: assert property (@(posedge clock) disable iff (!nrst)
    syncRange >= aux_io_pkg::RANGE_MIN && syncRange <= aux_io_pkg::RANGE_MAX
    && syncSpeed <= aux_io_pkg::SPEED_MAX)
    else $error("sync setup out of range");
endmodule : aux_io_event_controller
`default_nettype wire

// ### tb/aux_io_field_model.sv
// Purpose: far side model: relay coils on the two open-drain outputs
// Assumes: each open-drain pin carries a pull-up to the logic rail
// Notes:   a released pin reads high, never the last driven value
`default_nettype none
module aux_io_field_model (
  input  wire logic       relayFetOn_a,
  input  wire logic       relayFetOn_b,
  output logic [1:0]      relayPin
);
  timeunit 1ns;
  timeprecision 100ps;
  // fet on sinks the pull-up, so the coil side sees a low pin
  assign relayPin = {~relayFetOn_a, ~relayFetOn_b};
endmodule : aux_io_field_model
`default_nettype wire

// ### tb/aux_io_event_controller_tb.sv
// Purpose: self-checking bench for the aux i/o event controller
// Assumes: debounce runs at the package rate, one ms is 40000 clocks
// Notes:   driver queues due cycle, mask and value; monitor compares
`default_nettype none
module aux_io_event_controller_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int due; logic [63:0] m; logic [63:0] v;} note_type;
  localparam logic [63:0] M_TS  = 64'h1 << 44;
  localparam logic [63:0] M_RC  = 64'h1 << 45;
  localparam logic [63:0] M_ST  = 64'h1 << 46;
  localparam logic [63:0] M_LV0 = 64'h1 << 53;
  logic clock = 1'b0;
  logic nrst  = 1'b0;
  int   cyc, err_count, num_checks;
  note_type q [$];
  note_type n;
  aux_io_pkg::status_type       st = '0;
  aux_io_pkg::status_type       rs;
  aux_io_pkg::source_type       src [4];
  aux_io_pkg::source_type       s;
  aux_io_pkg::strobe_cfg_type   scfg = '0;
  aux_io_pkg::contact_mode_type cmode = aux_io_pkg::CONTACT_IGNORED;
  aux_io_pkg::sync_cfg_type     sc = '0;
  aux_io_pkg::sync_cfg_type     rsc;
  logic [23:0] fms [3];
  logic [63:0] ev;
  logic [3:0]  flip = '0;
  logic [3:0]  o, rf;
  logic [2:0]  pin = '0;
  logic [2:0]  rp, lv, lvl, rise, fall;
  logic [1:0]  rm, rpin;
  logic        pchg = 1'b0, cclose = 1'b0, panel = 1'b0, ten = 1'b0;
  logic        timm = 1'b0, slaunch = 1'b0, tpin = 1'b0, armed = 1'b0;
  logic        phase = 1'b0, rcc, rpn, erc;
  logic        ttlA, ttlB, fetA, fetB, strobe, rclose, tstart, lock, line;
  logic [15:0] er, ph, rg;
  logic [9:0]  es, sp;
  wire logic [63:0] obs = {2'b00, rpin, ttlA, ttlB, fetA, fetB, lvl, rise,
                           fall, strobe, rclose, tstart, lock, line, ph, rg, sp};

  aux_io_event_controller dut (
    .clock(clock), .nrst(nrst), .status(st), .outSource(src),
    .polarity_flip(flip), .inPin(pin), .filterMs(fms), .strobeCfg(scfg),
    .paramChanged(pchg), .contactMode(cmode), .contactClosed(cclose),
    .panelRelayOn(panel), .triggerEnable(ten), .triggerImmediate(timm),
    .self_launch(slaunch), .triggerPin(tpin), .runArmed(armed),
    .phaseReached(phase), .syncCfg(sc), .ttl_out_a(ttlA), .ttl_out_b(ttlB),
    .relayFetOn_a(fetA), .relayFetOn_b(fetB), .inLevel(lvl), .inRise(rise),
    .inFall(fall), .strobe(strobe), .relayClose(rclose),
    .transientStart(tstart), .syncLock(lock), .syncUseLine(line),
    .syncPhase(ph), .syncRange(rg), .syncSpeed(sp));
  aux_io_field_model field (
    .relayFetOn_a(fetA), .relayFetOn_b(fetB), .relayPin(rpin));

  always #12.5 clock = ~clock;

  task automatic wrap_up();
    if (err_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  task automatic note(int d, logic [63:0] m, logic [63:0] v);
    q.push_back('{cyc + d, m, v});
  endtask : note

  function automatic logic pick(aux_io_pkg::source_type k,
                                aux_io_pkg::status_type t);
    case (k)
      aux_io_pkg::SRC_FAULT:       return t.fault;
      aux_io_pkg::SRC_FORM:        return t.singleForm;
      aux_io_pkg::SRC_HIGH:        return 1'b1;
      aux_io_pkg::SRC_RELAY:       return t.relayOn;
      aux_io_pkg::SRC_PROGRAM:     return t.programRun;
      aux_io_pkg::SRC_REMOTE:      return t.remote;
      aux_io_pkg::SRC_TRANSIENT:   return t.transientActive;
      aux_io_pkg::SRC_TRANSFORMER: return t.transformer_path_flag;
      default:                     return 1'b0;
    endcase
  endfunction : pick

  task automatic quiet();
    @(posedge clock);
    st <= '0;
    pin <= '0;
    panel <= 1'b0;
    pchg <= 1'b0;
    cmode <= aux_io_pkg::CONTACT_IGNORED;
    repeat (4) @(posedge clock);
  endtask : quiet

  // relay close lags one clock, and its strobe one clock more
  task automatic strobe_case(int k);
    @(posedge clock);
    if (k == 0) pchg <= 1'b1;
    if (k == 1) st.transientActive <= 1'b1;
    if (k == 2) panel <= 1'b1;
    if (k == 2) note(1, M_RC | M_ST, M_RC);
    note(k == 2 ? 2 : 1, M_ST, M_ST);
    note(k == 2 ? 41 : 40, M_ST, M_ST);
    note(k == 2 ? 42 : 41, M_ST, 64'h0);
    @(posedge clock);
    pchg <= 1'b0;
    repeat (50) @(posedge clock);
    quiet();
  endtask : strobe_case

  task automatic trig(logic sl, logic im, logic ar, logic x);
    @(posedge clock);
    {slaunch, timm, armed, ten, phase, tpin} <= {sl, im, ar, 3'b100};
    @(posedge clock);
    tpin <= 1'b1;
    note(1, M_TS, x ? M_TS : 64'h0);
    note(2, M_TS, 64'h0);
    repeat (2) @(posedge clock);
  endtask : trig

  // count only after comparing: a note due one clock on is then looked
  // at after the edge that samples the stimulus, not half a cycle early
  always @(negedge clock) begin
    while (q.size() > 0 && q[0].due <= cyc) begin
      n = q.pop_front();
      num_checks++;
      if ((obs & n.m) !== (n.v & n.m) || n.due != cyc) begin
        err_count++;
        $display("wrong value at %0t: got %h expected %h", $time,
                 obs & n.m, n.v & n.m);
      end
    end
    cyc++;
  end

  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    wrap_up();
  end

  initial begin
    foreach (src[i]) src[i] = aux_io_pkg::SRC_LOW;
    foreach (fms[i]) fms[i] = '0;
    void'($urandom(32'hc91f));
    @(posedge clock);
    note(1, '1, (64'h3 << 60) | (64'(aux_io_pkg::RANGE_MIN) << 10)
             | 64'(aux_io_pkg::SPEED_MIN));
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    lv = '0;
    repeat (200) begin
      @(posedge clock);
      rs = 7'($urandom);
      rp = 3'($urandom);
      rm = 2'($urandom_range(2));
      {rcc, rpn} = 2'($urandom);
      rf = 4'($urandom);
      flip <= rf;
      for (int i = 0; i < 4; i++) begin
        s = aux_io_pkg::source_type'($urandom_range(8));
        src[i] <= s;
        o[i] = pick(s, rs) ^ rf[i];
      end
      rsc = 44'({$urandom, $urandom});
      rsc.lockRange = $urandom_range(1) ? 16'($urandom_range(20))
                                        : 16'hC340 + 16'($urandom_range(40));
      rsc.speed = $urandom_range(1) ? 10'($urandom_range(200))
                                    : 10'h3D0 + 10'($urandom_range(47));
      er = (rsc.lockRange < aux_io_pkg::RANGE_MIN) ? aux_io_pkg::RANGE_MIN
         : (rsc.lockRange > aux_io_pkg::RANGE_MAX) ? aux_io_pkg::RANGE_MAX
         : rsc.lockRange;
      es = (rsc.speed < aux_io_pkg::SPEED_MIN) ? aux_io_pkg::SPEED_MIN
         : (rsc.speed > aux_io_pkg::SPEED_MAX) ? aux_io_pkg::SPEED_MAX
         : rsc.speed;
      erc = (rm == 2'h0) ? rpn : (rm == 2'h1) ? (rcc & rpn) : (rcc | rpn);
      ev = {2'b00, ~o[2], ~o[3], o[0], o[1], o[2], o[3], rp, rp & ~lv,
            ~rp & lv, 1'b0, erc, 1'b0, rsc.enable, rsc.lineSource,
            rsc.phaseOffset, er, es};
      note(1, '1, ev);
      lv = rp;
      st <= rs;
      pin <= rp;
      cmode <= aux_io_pkg::contact_mode_type'(rm);
      cclose <= rcc;
      panel <= rpn;
      sc <= rsc;
      pchg <= 1'($urandom);
    end
    quiet();
    scfg <= 3'b111;
    quiet();
    strobe_case(0);
    strobe_case(1);
    strobe_case(2);
    scfg <= '0;
    trig(1'b0, 1'b1, 1'b0, 1'b0);
    trig(1'b1, 1'b1, 1'b0, 1'b1);
    trig(1'b0, 1'b1, 1'b1, 1'b1);
    trig(1'b0, 1'b0, 1'b1, 1'b0);
    phase <= 1'b1;
    note(1, M_TS, M_TS);
    @(posedge clock);
    {phase, ten} <= 2'b00;
    // one ms filter: a short pulse is dropped, a steady level accepted
    fms[0] <= 24'h000001;
    repeat (3) @(posedge clock);
    pin[0] <= 1'b1;
    note(50, M_LV0, 64'h0);
    repeat (100) @(posedge clock);
    pin[0] <= 1'b0;
    repeat (5) @(posedge clock);
    pin[0] <= 1'b1;
    note(39990, M_LV0, 64'h0);
    note(40010, M_LV0, M_LV0);
    repeat (40020) @(posedge clock);
    wrap_up();
  end
endmodule : aux_io_event_controller_tb
`default_nettype wire
